// >>> wake_ctrl_b.sv
// Purpose: Standby-release mode control for four wake channels
// Assumes: Avalon-MM word addressing, sources synchronous to CLOCK
// Notes:   Each channel owns one byte lane of the mode register
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Ext irq5 level field in bits 14-12 selects low, high, fall, rise, both; 101-111 prohibited.
// - Ext irq4 level field in bits 6-4 uses the same codes with the upper three prohibited.
// - Bits 27-26 read the remote rx0 detected edge: none, rising, falling, both.
// - Bits 19-18 read the cec rx detected edge with the same four codes.
// - Bits 11-10 read the ext irq5 detected edge with the same four codes.
// - Bits 3-2 read the ext irq4 detected edge with the same four codes.
// - Enable bits 24, 16, 8 and 0 let a channel release standby when set and block it when clear.
// - Edge status is meaningful only in both-edges mode and then tells which edge woke.
// - Clearing a channel through the interrupt clear register also clears its edge status.
module wake_ctrl_b
  import wake_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [1:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        EXTERNAL_INTERRUPT_FOUR,
  input  wire logic        EXTERNAL_INTERRUPT_FIVE,
  input  wire logic        CONTROL_BUS_RECEIVE_EVENT,
  input  wire logic        REMOTE_RECEIVE_EVENT_0,
  output logic      [3:0]  CHAN_REQ,
  output logic             WAKE_REQ
);
  typedef struct packed {
    bus_state_t            bus;
    logic [31:0]           rdata;
    logic [NUM_CH-1:0][2:0] level;
    logic [NUM_CH-1:0]     enable;
    logic [NUM_CH-1:0]     clear;
    logic [NUM_CH-1:0]     req;
    logic                  wake;
  } top_state_t;

  top_state_t        st;
  top_state_t        next_st;
  logic [1:0]        rst_sync;
  logic              rst_n;
  logic [NUM_CH-1:0] sources;
  logic [NUM_CH-1:0] chan_req;
  logic [NUM_CH-1:0][1:0] chan_status;
  logic              accept;
  logic [31:0]       mode_word;

  // Release is synchronised; assertion stays asynchronous
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign sources = {REMOTE_RECEIVE_EVENT_0, CONTROL_BUS_RECEIVE_EVENT,
                    EXTERNAL_INTERRUPT_FIVE, EXTERNAL_INTERRUPT_FOUR};

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      wake_chan_if cif ();
      assign cif.level_sel  = st.level[g];
      assign cif.enable     = st.enable[g];
      assign cif.clear      = st.clear[g];
      assign cif.source     = sources[g];
      assign chan_req[g]    = cif.request;
      assign chan_status[g] = cif.edge_status;
      wake_channel u_chan (
        .clk   (CLOCK),
        .rst_n (rst_n),
        .ch    (cif.chan)
      );
    end
  endgenerate

  // One byte per channel; reserved and undefined bits read 0
  always_comb begin
    mode_word = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      mode_word[i*CH_STRIDE+LS_POS +: 3] = st.level[i];
      mode_word[i*CH_STRIDE+ST_POS +: 2] = chan_status[i];
      mode_word[i*CH_STRIDE+EN_POS]      = st.enable[i];
    end
  end

  assign accept = (AVS_READ | AVS_WRITE) & (st.bus == BUS_ACK);

  always_comb begin
    next_st       = st;
    next_st.clear = '0;
    next_st.req   = chan_req;
    next_st.wake  = |chan_req;
    case (st.bus)
      BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          next_st.bus = BUS_ACK;
          if (AVS_ADDRESS == ADDR_MODE_B) begin
            next_st.rdata = mode_word;
          end else if (AVS_ADDRESS == ADDR_REQ_STAT) begin
            next_st.rdata = {{(32-NUM_CH){1'b0}}, st.req};
          end else begin
            next_st.rdata = '0;
          end
        end
      end
      BUS_ACK: begin
        next_st.bus = BUS_IDLE;
      end
      default: begin
        next_st.bus = BUS_IDLE;
      end
    endcase
    if (accept && AVS_WRITE) begin
      // Both fields of a lane store as written; ordering is software's job
      for (int i = 0; i < NUM_CH; i++) begin
        if (AVS_ADDRESS == ADDR_MODE_B && AVS_BYTEENABLE[i]) begin
          next_st.level[i]  = AVS_WRITEDATA[i*CH_STRIDE+LS_POS +: 3];
          next_st.enable[i] = AVS_WRITEDATA[i*CH_STRIDE+EN_POS];
        end else if (AVS_ADDRESS == ADDR_CLEAR && AVS_BYTEENABLE[0]) begin
          next_st.clear[i]  = AVS_WRITEDATA[i];
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.bus    <= BUS_IDLE;
      st.level  <= {NUM_CH{LVL_RESET}};
    end else begin
      st <= next_st;
    end
  end

  assign AVS_READDATA    = st.rdata;
  // One-hot idle bit is the flop itself, so waitrequest has no decode
  assign AVS_WAITREQUEST = st.bus[0];
  assign CHAN_REQ        = st.req;
  assign WAKE_REQ        = st.wake;

  a_bus_answer: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (AVS_READ || AVS_WRITE) && st.bus == BUS_IDLE |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("Bus answer not one cycle after request");
  a_mode_write: assert property (@(posedge CLOCK) disable iff (!rst_n)
    accept && AVS_WRITE && AVS_ADDRESS == ADDR_MODE_B && AVS_BYTEENABLE[1]
    |=> st.level[1] == $past(AVS_WRITEDATA[14:12]))
    else $error("Ext irq5 level field not written");
  a_enable_write: assert property (@(posedge CLOCK) disable iff (!rst_n)
    accept && AVS_WRITE && AVS_ADDRESS == ADDR_MODE_B && AVS_BYTEENABLE[3]
    |=> st.enable[3] == $past(AVS_WRITEDATA[24]))
    else $error("Remote rx0 enable not written");
  a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!rst_n)
    !AVS_WAITREQUEST |-> AVS_READDATA[31] == 1'b0 && AVS_READDATA[23] == 1'b0
                       && AVS_READDATA[15] == 1'b0 && AVS_READDATA[7] == 1'b0)
    else $error("Reserved bit read nonzero");
  a_wake_follow: assert property (@(posedge CLOCK) disable iff (!rst_n)
    |chan_req |=> WAKE_REQ ##0 CHAN_REQ == $past(chan_req))
    else $error("Wake request did not follow channels");
  a_clear_pulse: assert property (@(posedge CLOCK) disable iff (!rst_n)
    accept && AVS_WRITE && AVS_ADDRESS == ADDR_CLEAR && AVS_BYTEENABLE[0]
    && AVS_WRITEDATA[2] |=> st.clear[2] ##1 !st.clear[2])
    else $error("Clear pulse malformed");
endmodule : wake_ctrl_b
`default_nettype wire

// >>> wake_pkg.sv
// Purpose: Shared constants for the standby-release mode control block
// Assumes: Word-addressed Avalon-MM slave, four wake channels
// Notes:   Channel 0 ext irq4, 1 ext irq5, 2 cec rx, 3 remote rx0
package wake_pkg;
  localparam int          NUM_CH        = 4;
  localparam int          CH_STRIDE     = 8;
  localparam int          EN_POS        = 0;
  localparam int          ST_POS        = 2;
  localparam int          LS_POS        = 4;
  localparam logic [1:0]  ADDR_MODE_B   = 2'h0;
  localparam logic [1:0]  ADDR_CLEAR    = 2'h1;
  localparam logic [1:0]  ADDR_REQ_STAT = 2'h2;
  localparam logic [2:0]  LVL_LOW       = 3'h0;
  localparam logic [2:0]  LVL_HIGH      = 3'h1;
  localparam logic [2:0]  LVL_FALL      = 3'h2;
  localparam logic [2:0]  LVL_RISE      = 3'h3;
  localparam logic [2:0]  LVL_BOTH      = 3'h4;
  localparam logic [2:0]  LVL_RESET     = LVL_FALL;
  localparam logic [1:0]  EDGE_NONE     = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_FALL     = 2'h2;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;
endpackage : wake_pkg

// >>> wake_chan_if.sv
// Purpose: Carrier between the register file and one wake channel
// Assumes: Single clock domain
// Notes:   ctrl side is the register file
`timescale 1ns/100ps
`default_nettype none
interface wake_chan_if;
  logic [2:0] level_sel;
  logic       enable;
  logic       clear;
  logic       source;
  logic       request;
  logic [1:0] edge_status;
  modport ctrl (output level_sel, output enable, output clear, output source,
                input request, input edge_status);
  modport chan (input level_sel, input enable, input clear, input source,
                output request, output edge_status);
endinterface : wake_chan_if
`default_nettype wire

// >>> wake_channel.sv
// Purpose: One wake channel: level/edge detection and edge status
// Assumes: Source synchronous to clk
// Notes:   Prohibited codes never raise a request
`timescale 1ns/100ps
`default_nettype none
module wake_channel
  import wake_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  wake_chan_if.chan  ch
);
  typedef struct packed {
    logic       prev;
    logic       primed;
    logic       request;
    logic [1:0] status;
  } chan_state_t;

  chan_state_t st;
  chan_state_t next_st;
  logic        rise;
  logic        fall;
  logic        hit;

  always_comb begin
    rise = st.primed & ch.source & ~st.prev;
    fall = st.primed & ~ch.source & st.prev;
    case (ch.level_sel)
      LVL_LOW:  hit = ~ch.source;
      LVL_HIGH: hit = ch.source;
      LVL_FALL: hit = fall;
      LVL_RISE: hit = rise;
      LVL_BOTH: hit = rise | fall;
      default:  hit = 1'b0;
    endcase
    next_st         = st;
    next_st.prev    = ch.source;
    next_st.primed  = 1'b1;
    next_st.request = ch.enable & hit;
    // Set wins over clear so an edge in the clear cycle is kept
    next_st.status  = ch.clear ? EDGE_NONE : st.status;
    if (ch.enable && ch.level_sel == LVL_BOTH) begin
      next_st.status = next_st.status | {fall, rise};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ch.request     = st.request;
  assign ch.edge_status = st.status;

  a_low_level_req: assert property (@(posedge clk) disable iff (!rst_n)
    ch.enable && ch.level_sel == LVL_LOW && !ch.source |=> ch.request)
    else $error("Low level did not raise request");
  a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !ch.enable |=> !ch.request)
    else $error("Disabled channel raised request");
  a_prohibited_code: assert property (@(posedge clk) disable iff (!rst_n)
    ch.level_sel > LVL_BOTH |=> !ch.request)
    else $error("Prohibited code raised request");
  a_both_rise_stat: assert property (@(posedge clk) disable iff (!rst_n)
    ch.enable && ch.level_sel == LVL_BOTH && rise |=> ch.edge_status[0] && ch.request)
    else $error("Rising edge not recorded");
  a_both_fall_stat: assert property (@(posedge clk) disable iff (!rst_n)
    ch.enable && ch.level_sel == LVL_BOTH && fall |=> ch.edge_status[1] && ch.request)
    else $error("Falling edge not recorded");
  a_clear_status: assert property (@(posedge clk) disable iff (!rst_n)
    ch.clear && !rise && !fall |=> ch.edge_status == EDGE_NONE)
    else $error("Clear did not empty status");
  a_status_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !ch.clear && ch.level_sel != LVL_BOTH |=> $stable(ch.edge_status))
    else $error("Status changed outside both-edge mode");
endmodule : wake_channel
`default_nettype wire

// >>> wake_src_model.sv
// Purpose: Far-side model of the four wake sources
// Assumes: Sources are synchronous to the block clock
// Notes:   Levels change only just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module wake_src_model (
  input  wire logic       clk,
  output logic      [3:0] src
);
  initial src = 4'h0;
  // Bit order: irq4, irq5, cec rx, remote rx0
  task drive(input logic [3:0] v);
    @(posedge clk);
    src <= v;
  endtask : drive
endmodule : wake_src_model
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the wake mode block
// Assumes: One request at a time on the register bus
// Notes:   Source model drives the wake pins
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clock, rst_n, rd, wr, wait_req, wake;
  logic [1:0]  adr;
  logic [31:0] wd, rdata, q;
  logic [3:0]  be, req;
  wire  [3:0]  src;
  int          err_count, comparisons;

  wake_src_model m (.clk(clock), .src(src));
  wake_ctrl_b dut (
    .CLOCK                    (clock),
    .RST_N                    (rst_n),
    .AVS_ADDRESS              (adr),
    .AVS_READ                 (rd),
    .AVS_WRITE                (wr),
    .AVS_WRITEDATA            (wd),
    .AVS_BYTEENABLE           (be),
    .AVS_READDATA             (rdata),
    .AVS_WAITREQUEST          (wait_req),
    .EXTERNAL_INTERRUPT_FOUR  (src[0]),
    .EXTERNAL_INTERRUPT_FIVE  (src[1]),
    .CONTROL_BUS_RECEIVE_EVENT(src[2]),
    .REMOTE_RECEIVE_EVENT_0   (src[3]),
    .CHAN_REQ                 (req),
    .WAKE_REQ                 (wake)
  );

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is seen low at an edge
  task bus(input logic w, input logic [1:0] a, input logic [31:0] d, input logic [3:0] e);
    int n;
    n = 0;
    @(posedge clock);
    adr <= a;
    wd <= d;
    be <= e;
    rd <= !w;
    wr <= w;
    // No cycle limit here; only the watchdog ends a hung wait
    do begin
      @(posedge clock);
      n++;
    end while (wait_req !== 1'b0);
    q = rdata;
    chk(n, 32'h2);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task rd_chk(input logic [1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(q, exp);
  endtask : rd_chk

  // Channel flop, then output flop: two edges after the change
  task src_chk(input logic [3:0] v, input logic [3:0] exp);
    m.drive(v);
    @(posedge clock);
    @(posedge clock);
    #1;
    chk({27'h0, wake, req}, {27'h0, |exp, exp});
  endtask : src_chk

  task t_reset;
    rd_chk(2'h0, 32'h20202020);
    rd_chk(2'h3, 32'h0);
    rd_chk(2'h2, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task t_rise;
    bus(1'b1, 2'h0, 32'h30, 4'h1);
    src_chk(4'h1, 4'h0);
    src_chk(4'h0, 4'h0);
    bus(1'b1, 2'h0, 32'h31, 4'h1);
    rd_chk(2'h0, 32'h20202031);
    src_chk(4'h1, 4'h1);
    src_chk(4'h1, 4'h0);
    src_chk(4'h0, 4'h0);
    rd_chk(2'h0, 32'h20202031);
    $display("test rise done");
  endtask : t_rise

  task t_both;
    bus(1'b1, 2'h0, 32'h4000, 4'h2);
    bus(1'b1, 2'h0, 32'h4100, 4'h2);
    src_chk(4'h2, 4'h2);
    rd_chk(2'h0, 32'h20204531);
    src_chk(4'h0, 4'h2);
    rd_chk(2'h0, 32'h20204D31);
    bus(1'b1, 2'h1, 32'h2, 4'h1);
    rd_chk(2'h0, 32'h20204131);
    $display("test both done");
  endtask : t_both

  task t_periph;
    bus(1'b1, 2'h0, 32'h30303131, 4'hC);
    src_chk(4'hC, 4'h0);
    bus(1'b1, 2'h0, 32'h31313131, 4'hC);
    src_chk(4'h0, 4'h0);
    src_chk(4'h4, 4'h4);
    src_chk(4'hC, 4'h8);
    rd_chk(2'h0, 32'h31314131);
    $display("test periph done");
  endtask : t_periph

  task t_level;
    bus(1'b1, 2'h0, 32'h11, 4'h1);
    src_chk(4'hD, 4'h1);
    src_chk(4'hD, 4'h1);
    rd_chk(2'h2, 32'h1);
    bus(1'b1, 2'h0, 32'h5101, 4'h3);
    src_chk(4'hF, 4'h0);
    src_chk(4'hE, 4'h1);
    bus(1'b1, 2'h0, 32'h21, 4'h1);
    src_chk(4'hF, 4'h0);
    src_chk(4'hE, 4'h1);
    $display("test level done");
  endtask : t_level

  // Mid-run reset must restore every field whatever ran before
  task t_rerst;
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    #1;
    chk({26'h0, wait_req, wake, req}, 32'h20);
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk(2'h0, 32'h20202020);
    rd_chk(2'h2, 32'h0);
    $display("test rerst done");
  endtask : t_rerst

  task end_sim;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    end_sim();
  end

  initial begin
    {rst_n, rd, wr, adr, wd, be} = '0;
    err_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_rise();
    t_both();
    t_periph();
    t_level();
    t_rerst();
    end_sim();
  end
endmodule : tb
`default_nettype wire
